// [timer_counter_pkg.sv]
// Shared constants and carrier types for the 8-bit timer/event counter.
// Assumes a 32-bit APB slave port and a single system clock domain.

`default_nettype none

package timer_counter_pkg;

	// ----------------------------------------------------------------
	// Bus widths and register indices (byte address is four times index)
	// ----------------------------------------------------------------
	localparam int          APB_DATA_W        = 32;
	localparam int          APB_ADDR_W        = 12;
	localparam logic [9:0]  IDX_TIMER_CONTROL = 10'h028;
	localparam logic [9:0]  IDX_EDGE_SELECT   = 10'h029;
	localparam logic [9:0]  IDX_COMPARE       = 10'h02A;
	localparam logic [9:0]  IDX_CAPTURE       = 10'h02B;
	localparam logic [9:0]  IDX_STATUS        = 10'h02C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          CTRL_MODE_BIT     = 0;
	localparam int          CTRL_SRC_LSB      = 1;
	localparam int          CTRL_RUN_BIT      = 4;
	localparam int          CTRL_AUTO_CAPTURE_ENABLE_BIT     = 6;
	localparam int          EDGE_POL_BIT      = 0;

	// ----------------------------------------------------------------
	// Values after reset and encodings
	// ----------------------------------------------------------------
	localparam logic [7:0]  COMPARE_RESET     = 8'hFF;
	localparam logic [7:0]  CAPTURE_RESET     = 8'hFF;
	localparam logic        EDGE_POL_RESET    = 1'b0;
	localparam logic [2:0]  SRC_EXTERNAL      = 3'h7;
	localparam logic [2:0]  FS_LAST_CODE      = 3'h4;
	localparam logic        MODE_TIMER_EVENT  = 1'b0;
	localparam logic        MODE_CAPTURE      = 1'b1;
	localparam logic [7:0]  COUNT_TOP         = 8'hFF;

	// ----------------------------------------------------------------
	// Divider taps: code 000 divides by 2^FC_TAP_TOP (2^FS_TAP_TOP on the low-frequency path), each code one less
	// ----------------------------------------------------------------
	localparam int          PRESCALE_W        = 13;
	localparam int          FC_TAP_TOP        = 13;
	localparam int          FS_TAP_TOP        = 5;
	localparam int          FS_COUNT_W        = 5;

	typedef struct packed {
		logic       autoCaptureEnable;
		logic       runControl;
		logic [2:0] sourceClockSelect;
		logic       operatingModeSelect;
	} timer_control_t;

	typedef struct packed {
		logic tick;
		logic rise;
		logic fall;
	} source_events_t;

endpackage

`default_nettype wire

// [count_source.sv]
// Count source: internal divider taps and edge detection on the event pin.
// Assumes the event pin and low-frequency clock are synchronous to clk_sys.

`timescale 1ns/100ps
`default_nettype none

module count_source
	import timer_counter_pkg::*;
(
	input  wire logic                            clk_sys,
	input  wire logic                            resetn,
	input  wire logic [2:0]                      sourceClockSelect,
	input  wire logic                            dividerTapSelect,
	input  wire logic                            lowFreqClock,
	input  wire logic                            eventInputPin,
	output var  timer_counter_pkg::source_events_t events
);

	logic [PRESCALE_W-1:0] prescale;
	logic [FS_COUNT_W-1:0] lowCount;
	logic                  lowLevel;
	logic                  lowPrev;
	logic                  pinLevel;
	logic                  pinPrev;
	logic                  lowRise;
	logic                  tickNow;

	// A tap fires once every 2^k counts: when the low k bits are all ones.
	function automatic logic tapDue(input logic [PRESCALE_W-1:0] cnt, input int k);
		logic [PRESCALE_W-1:0] mask;
		mask = PRESCALE_W'((1 << k) - 1);
		return &(cnt | ~mask);
	endfunction

	// ----------------------------------------------------------------
	// Prescalers
	// ----------------------------------------------------------------
	// The fast prescaler runs freely so tap phase never depends on start.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prescale <= '0;
			lowCount <= '0;
			lowLevel <= 1'b0;
			lowPrev  <= 1'b0;
		end else begin
			prescale <= prescale + PRESCALE_W'(1);
			lowLevel <= lowFreqClock;
			lowPrev  <= lowLevel;
			if (lowRise) begin
				lowCount <= lowCount + FS_COUNT_W'(1);
			end
		end
	end

	assign lowRise = lowLevel & ~lowPrev;

	// Tap selection; the low-frequency path serves only codes 000 to 100.
	always_comb begin
		tickNow = 1'b0;
		if (sourceClockSelect == SRC_EXTERNAL) begin
			tickNow = 1'b0;
		end else if (dividerTapSelect && sourceClockSelect <= FS_LAST_CODE) begin
			tickNow = lowRise && tapDue(PRESCALE_W'(lowCount), FS_TAP_TOP - int'(sourceClockSelect));
		end else begin
			tickNow = tapDue(prescale, FC_TAP_TOP - int'(sourceClockSelect));
		end
	end

	// ----------------------------------------------------------------
	// Event pin edges and registered event outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pinLevel <= 1'b0;
			pinPrev  <= 1'b0;
			events   <= '0;
		end else begin
			pinLevel    <= eventInputPin;
			pinPrev     <= pinLevel;
			events.tick <= tickNow;
			events.rise <= pinLevel & ~pinPrev;
			events.fall <= ~pinLevel & pinPrev;
		end
	end

endmodule

`default_nettype wire

// [timer_counter_8bit_autocapture.sv]
// 8-bit up-counting timer/event counter with compare, auto-capture and an
// edge-triggered capture mode, reached over APB.
// Assumes an APB master on clk_sys and synchronous pin inputs.
//
// Design decision made here: the APB register port.

`timescale 1ns/100ps
`default_nettype none

// What this block does
// (RQ1) One 8-bit counter, compare and capture registers.
// (RQ2) Run off stops and zeroes the counter.
// (RQ3) Codes 000-110 pick taps, 111 the pin.
// (RQ4) Mode bit picks timer/event or capture.
// (RQ5) Software changes mode and source only stopped.
// (RQ6) Software keeps compare above one.
// (RQ7) Software uses auto-capture outside capture mode.
// (RQ8) Control bits 5 and 7 read undefined.
// (RQ9) Software never writes compare while running.
// (RQ10) STOP entry clears run control.
// (RQ11) Edge bit 0 resets low, picks count edge.
// (RQ12) Capture mode: edge bit picks interrupt edge.
// (RQ13) Edge register bits 7 to 1 undefined.
// (RQ14) Timer match raises interrupt, clears, keeps counting.
// (RQ15) Auto-capture copies the live count continuously.
// (RQ16) Zero after a match is never auto-captured.
// (RQ17) Event mode counts selected pin edges.
// (RQ18) Event match detected on the opposite edge.
// (RQ19) Pin phases last longer than one cycle.
// (RQ20) Match interrupt is a one-cycle pulse.
module timer_counter_8bit_autocapture
	import timer_counter_pkg::*;
(
	input  wire logic                                   clk_sys,
	input  wire logic                                   resetn,
	input  wire logic                                   psel,
	input  wire logic                                   penable,
	input  wire logic                                   pwrite,
	input  wire logic [timer_counter_pkg::APB_ADDR_W-1:0] paddr,
	input  wire logic [timer_counter_pkg::APB_DATA_W-1:0] pwdata,
	input  wire logic [3:0]                             pstrb,
	output logic      [timer_counter_pkg::APB_DATA_W-1:0] prdata,
	output logic                                        pready,
	output logic                                        pslverr,
	input  wire logic                                   stopEntry,
	input  wire logic                                   dividerTapSelect,
	input  wire logic                                   lowFreqClock,
	input  wire logic                                   eventInputPin,
	output logic                                        matchInterrupt
);

	timer_control_t ctrl;
	source_events_t events;
	logic [7:0]     upCount;
	logic [7:0]     compareValue;
	logic [7:0]     captureValue;
	logic           edgePolarity;
	logic           setupPhase;
	logic           writeNow;
	logic           externalSource;
	logic           countEdge;
	logic           oppositeEdge;
	logic           matchHit;
	logic           countStep;

	// True when the word index of the bus address selects a register.
	function automatic logic regHit(input logic [APB_ADDR_W-1:0] addr, input logic [9:0] idx);
		return addr[APB_ADDR_W-1:2] == idx;
	endfunction

	// Read value of one register; undefined control and edge bits read zero.
	function automatic logic [APB_DATA_W-1:0] readValue(input logic [APB_ADDR_W-1:0] addr,
		input timer_control_t c, input logic pol, input logic [7:0] cmp,
		input logic [7:0] cap, input logic [7:0] cnt);
		logic [7:0] value;
		value = 8'h00;
		if (regHit(addr, IDX_TIMER_CONTROL)) begin
			value[CTRL_AUTO_CAPTURE_ENABLE_BIT]                  = c.autoCaptureEnable;
			value[CTRL_RUN_BIT]                   = c.runControl;
			value[CTRL_SRC_LSB +: 3]              = c.sourceClockSelect;
			value[CTRL_MODE_BIT]                  = c.operatingModeSelect;
		end else if (regHit(addr, IDX_EDGE_SELECT)) begin
			value[EDGE_POL_BIT]                   = pol;
		end else if (regHit(addr, IDX_COMPARE)) begin
			value                                 = cmp;
		end else if (regHit(addr, IDX_CAPTURE)) begin
			value                                 = cap;
		end else if (regHit(addr, IDX_STATUS)) begin
			value                                 = cnt;
		end
		return {24'h000000, value};
	endfunction

	// True for any of the five mapped word indices.
	function automatic logic mapped(input logic [APB_ADDR_W-1:0] addr);
		return regHit(addr, IDX_TIMER_CONTROL) || regHit(addr, IDX_EDGE_SELECT) ||
			regHit(addr, IDX_COMPARE) || regHit(addr, IDX_CAPTURE) ||
			regHit(addr, IDX_STATUS);
	endfunction

	// ----------------------------------------------------------------
	// Count sources
	// ----------------------------------------------------------------
	count_source u_source (
		.clk_sys           (clk_sys),
		.resetn            (resetn),
		.sourceClockSelect (ctrl.sourceClockSelect),
		.dividerTapSelect  (dividerTapSelect),
		.lowFreqClock      (lowFreqClock),
		.eventInputPin     (eventInputPin),
		.events            (events)
	);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Setup phase prepares the answer so the access phase needs no wait.
	assign setupPhase = psel & ~penable;
	assign writeNow   = psel & penable & pready & pwrite & pstrb[0];

	// Read data and error are registered at setup, shown during access.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setupPhase;
			pslverr <= setupPhase & ~mapped(paddr);
			if (setupPhase && !pwrite) begin
				prdata <= readValue(paddr, ctrl, edgePolarity, compareValue,
					captureValue, upCount); // RQ8 RQ13
			end
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	// STOP entry wins over a write in the same cycle so the timer halts.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl <= '0;
		end else begin
			if (writeNow && regHit(paddr, IDX_TIMER_CONTROL)) begin
				ctrl.autoCaptureEnable   <= pwdata[CTRL_AUTO_CAPTURE_ENABLE_BIT];
				ctrl.runControl          <= pwdata[CTRL_RUN_BIT];
				ctrl.sourceClockSelect   <= pwdata[CTRL_SRC_LSB +: 3]; // RQ3
				ctrl.operatingModeSelect <= pwdata[CTRL_MODE_BIT]; // RQ4
			end
			if (stopEntry) begin
				ctrl.runControl <= 1'b0; // RQ10
			end
		end
	end

	// Edge polarity and compare; compare is trusted to be written stopped.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			edgePolarity <= EDGE_POL_RESET; // RQ11
			compareValue <= COMPARE_RESET;
		end else begin
			if (writeNow && regHit(paddr, IDX_EDGE_SELECT)) begin
				edgePolarity <= pwdata[EDGE_POL_BIT];
			end
			if (writeNow && regHit(paddr, IDX_COMPARE)) begin
				compareValue <= pwdata[7:0]; // RQ9
			end
		end
	end

	// ----------------------------------------------------------------
	// Counting decisions
	// ----------------------------------------------------------------
	// The polarity bit picks the count edge; the other edge checks match.
	// In capture mode the same selected edge is the interrupt edge.
	assign externalSource = ctrl.sourceClockSelect == SRC_EXTERNAL; // RQ3
	assign countEdge      = edgePolarity ? events.fall : events.rise; // RQ11 RQ12
	assign oppositeEdge   = edgePolarity ? events.rise : events.fall;

	// Rise and fall never coincide, so match and count cannot collide in
	// event mode; the pin phases are relied on to outlast a cycle.
	always_comb begin
		matchHit  = 1'b0;
		countStep = 1'b0;
		if (!ctrl.runControl) begin
			matchHit  = 1'b0;
			countStep = 1'b0;
		end else if (ctrl.operatingModeSelect == MODE_TIMER_EVENT) begin
			if (externalSource) begin
				matchHit  = oppositeEdge && upCount == compareValue; // RQ18 RQ19
				countStep = countEdge; // RQ17
			end else begin
				matchHit  = events.tick && upCount == compareValue; // RQ14
				countStep = events.tick && !matchHit;
			end
		end else begin
			matchHit  = countEdge; // RQ12
			countStep = events.tick && !matchHit && upCount != COUNT_TOP;
		end
	end

	// ----------------------------------------------------------------
	// Up-counter and match interrupt
	// ----------------------------------------------------------------
	// The counter holds the compare value for a full source period, then
	// clears on the next tick, so a compare of 0 or 1 would misbehave.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			upCount        <= 8'h00;
			matchInterrupt <= 1'b0;
		end else begin
			matchInterrupt <= matchHit; // RQ20
			if (!ctrl.runControl) begin
				upCount <= 8'h00; // RQ2
			end else if (matchHit) begin
				upCount <= 8'h00; // RQ14 RQ6
			end else if (countStep) begin
				upCount <= upCount + 8'h01; // RQ1
			end
		end
	end

	// ----------------------------------------------------------------
	// Capture register
	// ----------------------------------------------------------------
	// Auto-capture copies only incremented values, so the zero left by a
	// match never reaches the capture register.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			captureValue <= CAPTURE_RESET;
		end else if (ctrl.operatingModeSelect == MODE_TIMER_EVENT) begin
			if (ctrl.autoCaptureEnable && countStep) begin
				captureValue <= upCount + 8'h01; // RQ15 RQ16 RQ7
			end
		end else if (ctrl.runControl && oppositeEdge) begin
			captureValue <= upCount;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_stop_clears: // RQ2
	assert property (@(posedge clk_sys) disable iff (!resetn)
		!ctrl.runControl |=> upCount == 8'h00)
		else $error("Counter not zero while stopped.");

	chk_stop_entry: // RQ10
	assert property (@(posedge clk_sys) disable iff (!resetn)
		stopEntry |=> !ctrl.runControl ##1 upCount == 8'h00)
		else $error("STOP entry did not halt the timer.");

	chk_timer_match: // RQ14
	assert property (@(posedge clk_sys) disable iff (!resetn)
		ctrl.runControl && !externalSource && events.tick &&
		ctrl.operatingModeSelect == MODE_TIMER_EVENT && upCount == compareValue
		|=> matchInterrupt && upCount == 8'h00)
		else $error("Timer match did not clear and interrupt.");

	chk_match_pulse: // RQ20
	assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(matchInterrupt) |=> !matchInterrupt)
		else $error("Match interrupt wider than one cycle.");

	chk_event_count: // RQ17
	assert property (@(posedge clk_sys) disable iff (!resetn)
		ctrl.runControl && externalSource && countEdge && !stopEntry && !writeNow &&
		ctrl.operatingModeSelect == MODE_TIMER_EVENT
		|=> upCount == $past(upCount) + 8'h01)
		else $error("Selected pin edge not counted.");

	chk_event_match: // RQ18
	assert property (@(posedge clk_sys) disable iff (!resetn)
		ctrl.runControl && externalSource && oppositeEdge &&
		ctrl.operatingModeSelect == MODE_TIMER_EVENT && upCount == compareValue
		|=> matchInterrupt ##1 !matchInterrupt)
		else $error("Opposite edge at compare gave no interrupt.");

	chk_autocap_live: // RQ15
	assert property (@(posedge clk_sys) disable iff (!resetn)
		ctrl.autoCaptureEnable && countStep &&
		ctrl.operatingModeSelect == MODE_TIMER_EVENT
		|=> captureValue == upCount)
		else $error("Auto-capture missed the live count.");

	chk_autocap_zero: // RQ16
	assert property (@(posedge clk_sys) disable iff (!resetn)
		matchInterrupt && ctrl.operatingModeSelect == MODE_TIMER_EVENT
		|-> $stable(captureValue))
		else $error("Cleared zero was auto-captured.");

	chk_ctrl_undef: // RQ8
	assert property (@(posedge clk_sys) disable iff (!resetn)
		setupPhase && !pwrite && regHit(paddr, IDX_TIMER_CONTROL)
		|=> prdata[7] == 1'b0 && prdata[5] == 1'b0 && pready)
		else $error("Control read shows bits 7 or 5.");

	chk_capture_edge: // RQ12
	assert property (@(posedge clk_sys) disable iff (!resetn)
		ctrl.runControl && ctrl.operatingModeSelect == MODE_CAPTURE && countEdge
		|=> matchInterrupt && upCount == 8'h00)
		else $error("Capture edge gave no interrupt.");

endmodule

`default_nettype wire

// [event_source_model.sv]
// Behavioural model of the pulse source that drives the event pin.
// Assumes the pin is sampled on clk_sys; every phase lasts two cycles or more.

`timescale 1ns/100ps
`default_nettype none

module event_source_model (
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic       go,
	input  wire logic [7:0] pulses,
	input  wire logic [7:0] phaseLen,
	input  wire logic       idleLevel,
	output var  logic       eventInputPin,
	output var  logic       busy
);
	// ----------------------------------------------------------------
	// Pulse train generator
	// ----------------------------------------------------------------
	logic [8:0] phasesLeft;
	logic [7:0] phaseCnt;
	logic [7:0] width;

	// Short phases are stretched, so a slow sampler never misses a level.
	assign width = (phaseLen < 8'h02) ? 8'h02 : phaseLen;
	assign busy  = (phasesLeft != 9'h000) || (phaseCnt != 8'h00);

	// One toggle per phase; between trains the pin rests at the idle level.
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			eventInputPin <= idleLevel;
			phasesLeft    <= 9'h000;
			phaseCnt      <= 8'h00;
		end else if (phaseCnt != 8'h00) begin
			phaseCnt <= phaseCnt - 8'h01;
		end else if (phasesLeft != 9'h000) begin
			eventInputPin <= ~eventInputPin;
			phasesLeft    <= phasesLeft - 9'h001;
			phaseCnt      <= width - 8'h01;
		end else begin
			eventInputPin <= idleLevel;
			if (go) begin
				phasesLeft <= {pulses, 1'b0};
			end
		end
	end
endmodule

`default_nettype wire

// [timer_counter_8bit_autocapture_tb.sv]
// Self-checking bench for the 8-bit timer/event counter over APB.
// Assumes the event source model and a 100 MHz clk_sys.

`timescale 1ns/100ps
`default_nettype none

module timer_counter_8bit_autocapture_tb;
	import timer_counter_pkg::*;
	// ----------------------------------------------------------------
	// Stimulus, observation and bookkeeping
	// ----------------------------------------------------------------
	localparam logic [11:0] A_CTRL  = {IDX_TIMER_CONTROL, 2'b00};
	localparam logic [11:0] A_EDGE  = {IDX_EDGE_SELECT, 2'b00};
	localparam logic [11:0] A_CMP   = {IDX_COMPARE, 2'b00};
	localparam logic [11:0] A_CAP   = {IDX_CAPTURE, 2'b00};
	localparam logic [11:0] A_STAT  = {IDX_STATUS, 2'b00};
	localparam int          LF_HALF = 4;
	logic        clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, stopEntry = 1'b0, divSel = 1'b0, lowFreqClock = 1'b0;
	logic        go = 1'b0, idleLevel = 1'b0, prevIrq = 1'b0;
	logic        pready, pslverr, matchInterrupt, eventInputPin, busy;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic [3:0]  pstrb = 4'hF;
	logic [7:0]  pulses = 8'h00, phaseLen = 8'h14;
	int          miscompares = 0, samples_checked = 0, cycleNow = 0, lfCnt = 0;
	int          irqCount = 0, irqAtIdle = 0, wideIrq = 0, lastIrq = 0;

	timer_counter_8bit_autocapture u_timer_counter_8bit_autocapture (
		.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .stopEntry(stopEntry),
		.dividerTapSelect(divSel), .lowFreqClock(lowFreqClock),
		.eventInputPin(eventInputPin), .matchInterrupt(matchInterrupt));
	event_source_model u_event_source_model (
		.clk_sys(clk_sys), .resetn(resetn), .go(go), .pulses(pulses),
		.phaseLen(phaseLen), .idleLevel(idleLevel), .eventInputPin(eventInputPin),
		.busy(busy));

	always #5 clk_sys = ~clk_sys;

	// Slow clock runs free at eight system cycles a period, sampled as data.
	always @(posedge clk_sys) begin
		lfCnt = lfCnt + 1;
		if (lfCnt == LF_HALF) begin
			lfCnt = 0;
			lowFreqClock <= ~lowFreqClock;
		end
	end

	// Interrupts are logged with the pin level, which tells which edge fired them.
	always @(posedge clk_sys) begin
		cycleNow = cycleNow + 1;
		if (matchInterrupt === 1'b1) begin
			irqCount = irqCount + 1;
			lastIrq = cycleNow;
			if (eventInputPin === idleLevel) irqAtIdle = irqAtIdle + 1;
			if (prevIrq) wideIrq = wideIrq + 1;
		end
		prevIrq = (matchInterrupt === 1'b1);
	end

	task check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task checkNum(input string what, input int exp, input int got);
		samples_checked++;
		if (got != exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// One APB transfer; request is held until pready is sampled high.
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic err);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		check8("pready", 8'h01, {7'h00, pready});
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		logic [7:0] x;
		logic       e;
		apb(1'b1, a, d, x, e);
	endtask

	task rdc(input string what, input logic [11:0] a, input logic [7:0] exp);
		logic [7:0] x;
		logic       e;
		apb(1'b0, a, 8'h00, x, e);
		check8(what, exp, x);
	endtask

	task wait_irq(input int lim);
		int n0, k;
		n0 = irqCount;
		k = 0;
		while (irqCount == n0 && k < lim) begin
			@(posedge clk_sys);
			k++;
		end
		checkNum("interrupt arrival", n0 + 1, irqCount);
	endtask

	task train(input logic [7:0] n);
		int k;
		@(posedge clk_sys);
		pulses <= n;
		go <= 1'b1;
		@(posedge clk_sys);
		go <= 1'b0;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (busy === 1'b1 && k < 4000);
		checkNum("pulse train done", 0, int'(busy === 1'b1));
		repeat (8) @(posedge clk_sys);
	endtask

	task test_regs;
		logic [7:0] x;
		logic       e;
		rdc("control reset", A_CTRL, 8'h00);
		rdc("edge reset", A_EDGE, 8'h00);
		rdc("compare reset", A_CMP, COMPARE_RESET);
		rdc("capture reset", A_CAP, CAPTURE_RESET);
		wr(A_EDGE, 8'hFF);
		rdc("edge spare bits", A_EDGE, 8'h01);
		wr(A_EDGE, 8'h00);
		wr(A_CTRL, 8'hA0);
		rdc("control spare bits", A_CTRL, 8'h00);
		wr(A_CAP, 8'h55);
		rdc("capture read only", A_CAP, CAPTURE_RESET);
		apb(1'b0, 12'h000, 8'h00, x, e);
		check8("unmapped error", 8'h01, {7'h00, e});
	endtask

	task test_run_stop;
		logic [7:0] x;
		logic       e;
		wr(A_CMP, 8'hFF);
		wr(A_CTRL, 8'h1C);
		repeat (400) @(posedge clk_sys);
		apb(1'b0, A_STAT, 8'h00, x, e);
		checkNum("counter moving", 1, int'(x != 8'h00));
		wr(A_CTRL, 8'h0C);
		rdc("count after stop", A_STAT, 8'h00);
		repeat (300) @(posedge clk_sys);
		rdc("count while stopped", A_STAT, 8'h00);
		wr(A_CTRL, 8'h1C);
		stopEntry <= 1'b1;
		@(posedge clk_sys);
		stopEntry <= 1'b0;
		rdc("run after stop entry", A_CTRL, 8'h0C);
		rdc("count after stop entry", A_STAT, 8'h00);
	endtask

	// Every tap code on both divider paths; the slow fast-path codes are skipped.
	task test_taps;
		int per, t;
		for (int d = 0; d < 2; d++) begin
			for (int c = 0; c < 7; c++) begin
				if (d == 0 && c < 2) continue;
				per = (d == 1 && c <= 4) ? (32 >> c) * 2 * LF_HALF : (8192 >> c);
				divSel <= d[0];
				wr(A_CTRL, 8'h40 | {4'h0, c[2:0], 1'b0});
				wr(A_CMP, 8'h02);
				wr(A_CTRL, 8'h50 | {4'h0, c[2:0], 1'b0});
				wait_irq(4 * per + 64);
				t = lastIrq;
				rdc("capture after match", A_CAP, 8'h02);
				wait_irq(4 * per + 64);
				checkNum("match interval", 3 * per, lastIrq - t);
				wr(A_CTRL, 8'h00);
			end
		end
	endtask

	task test_event(input logic pol);
		int n0, i0;
		idleLevel <= pol;
		wr(A_EDGE, {7'h00, pol});
		wr(A_CMP, 8'h02);
		wr(A_CTRL, 8'h0E);
		wr(A_CTRL, 8'h1E);
		n0 = irqCount;
		i0 = irqAtIdle;
		train(8'h01);
		rdc("event count", A_STAT, 8'h01);
		train(8'h05);
		checkNum("event matches", 3, irqCount - n0);
		checkNum("matches on opposite edge", 3, irqAtIdle - i0);
		rdc("count after match", A_STAT, 8'h00);
		wr(A_CTRL, 8'h0E);
	endtask

	task test_capture(input logic pol);
		int n0, i0;
		idleLevel <= pol;
		wr(A_EDGE, {7'h00, pol});
		wr(A_CTRL, 8'h0D);
		wr(A_CTRL, 8'h1D);
		n0 = irqCount;
		i0 = irqAtIdle;
		train(8'h03);
		checkNum("capture interrupts", 3, irqCount - n0);
		checkNum("interrupts on wrong edge", 0, irqAtIdle - i0);
		wr(A_CTRL, 8'h00);
	endtask

	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		test_regs();
		test_run_stop();
		test_taps();
		test_event(1'b0);
		test_event(1'b1);
		test_capture(1'b0);
		test_capture(1'b1);
		checkNum("wide interrupt pulses", 0, wideIrq);
		print_verdict();
	end

	// The whole sequence needs about thirty thousand cycles.
	initial begin
		repeat (90000) @(posedge clk_sys);
		miscompares++;
		print_verdict();
	end
endmodule

`default_nettype wire
